// [core/scinb_top.sv]
/*
  serial ninth-bit, error-interrupt and shared data register block.
  assumes a shifter outside that delivers received characters and takes
  transmit characters, and software on the plain register port.
*/
`timescale 1ns/100ps
`include "scinb_regs.svh"
module scinb_top
  import scinb_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rx_ready,
  input wire logic [8:0] i_rx_char,
  input wire logic [2:0] i_rx_err,
  input wire logic i_tx_take,
  output logic o_tx_valid,
  output logic [8:0] o_tx_char,
  output logic o_nine_bit,
  output logic o_tx_line_oe,
  output logic o_err_irq
);
  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // -------------------------------------------------------------
  // sub-blocks
  // -------------------------------------------------------------
  scinb_rx_if rx_bus ();
  logic hold_full;
  scinb_char_t hold_data;
  logic data_wr;
  logic data_rd;
  logic stat_rd;
  logic [7:0] c3_reg;
  logic [7:0] c3_next;

  scinb_rx_capture u_rx (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_ready(i_rx_ready),
    .i_data(i_rx_char),
    .i_err(i_rx_err),
    .rx(rx_bus.src)
  );

  scinb_tx_hold u_tx (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_load(data_wr),
    .i_data({c3_reg[`SCINB_C3_TX9], i_wdata}),
    .i_take(i_tx_take),
    .o_full(hold_full),
    .o_data(hold_data)
  );

  // -------------------------------------------------------------
  // register state
  // -------------------------------------------------------------
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] rxbuf_reg;
  logic [7:0] rxbuf_next;
  logic rdf_reg;
  logic rdf_next;
  logic ovr_reg;
  logic ovr_next;
  logic nse_reg;
  logic nse_next;
  logic frm_reg;
  logic frm_next;
  logic par_reg;
  logic par_next;
  scinb_arm_e rx_arm_reg;
  scinb_arm_e rx_arm_next;
  scinb_arm_e tx_arm_reg;
  scinb_arm_e tx_arm_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic oe_reg;
  logic oe_next;
  logic tde;
  logic [7:0] status_val;

  // transmit buffer empty when the hold stage is free
  assign tde = ~hold_full;
  assign status_val = {tde, 1'b0, rdf_reg, 1'b0, ovr_reg, nse_reg, frm_reg, par_reg};

  // -------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------
  always_comb begin
    data_wr = 1'b0;
    data_rd = 1'b0;
    stat_rd = 1'b0;
    if (i_addr == `SCINB_OFF_DATA) begin
      data_wr = i_wr;
      data_rd = i_rd;
    end else if (i_addr == `SCINB_OFF_STATUS_ONE) begin
      stat_rd = i_rd;
    end
  end

  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  always_comb begin
    c3_next = c3_reg;
    cfg_next = cfg_reg;
    rxbuf_next = rxbuf_reg;
    rdf_next = rdf_reg;
    ovr_next = ovr_reg;
    nse_next = nse_reg;
    frm_next = frm_reg;
    par_next = par_reg;
    rx_arm_next = rx_arm_reg;
    tx_arm_next = tx_arm_reg;
    rdata_next = 8'h00;

    // ninth transmit bit only changes on control writes
    if (i_wr && i_addr == `SCINB_OFF_CONTROL_THREE) begin
      c3_next[`SCINB_C3_TX9] = i_wdata[`SCINB_C3_TX9];
      c3_next[`SCINB_C3_DIR] = i_wdata[`SCINB_C3_DIR];
      c3_next[3:0] = i_wdata[3:0];
    end
    if (i_wr && i_addr == `SCINB_OFF_CONFIG) begin
      cfg_next = {5'h00, i_wdata[2:0]};
    end

    // status read arms the clearing sequences
    if (stat_rd) begin
      rx_arm_next = (rdf_reg | ovr_reg | nse_reg | frm_reg | par_reg) ? SCINB_ARM_SET : SCINB_ARM_IDLE;
      tx_arm_next = tde ? SCINB_ARM_SET : SCINB_ARM_IDLE;
    end

    if (data_rd && rx_arm_reg == SCINB_ARM_SET) begin
      rdf_next = 1'b0;
      ovr_next = 1'b0;
      nse_next = 1'b0;
      frm_next = 1'b0;
      par_next = 1'b0;
      rx_arm_next = SCINB_ARM_IDLE;
    end
    // data write completes transmit-empty clear (empty drops via hold)
    if (data_wr) begin
      tx_arm_next = SCINB_ARM_IDLE;
    end

    // new character: set wins over a clear in the same cycle
    if (rx_bus.load) begin
      if (rdf_reg && rdf_next) begin
        // overrun drops the new character and its errors
        ovr_next = 1'b1;
      end else begin
        rdf_next = 1'b1;
        rxbuf_next = rx_bus.data[7:0];
        // ninth bit captured with the byte
        c3_next[`SCINB_C3_RX9] = rx_bus.data[8];
        nse_next = rx_bus.noise;
        frm_next = rx_bus.framing;
        par_next = rx_bus.parity;
      end
    end

    // read data, one cycle after the strobe
    if (i_rd) begin
      if (i_addr == `SCINB_OFF_STATUS_ONE) begin
        rdata_next = status_val;
      end else if (i_addr == `SCINB_OFF_CONTROL_THREE) begin
        // ninth received bit sits in the top bit
        rdata_next = {c3_reg[`SCINB_C3_RX9] & cfg_reg[`SCINB_CF_NINE], c3_reg[6:5], 1'b0, c3_reg[3:0]};
      end else if (i_addr == `SCINB_OFF_DATA) begin
        rdata_next = rxbuf_reg;
      end else if (i_addr == `SCINB_OFF_CONFIG) begin
        rdata_next = cfg_reg;
      end
    end

    irq_next = (ovr_next & c3_next[`SCINB_C3_OVERRUN_IRQ_EN]) | (nse_next & c3_next[`SCINB_C3_NOISE_IRQ_EN])
             | (frm_next & c3_next[`SCINB_C3_FRAMING_IRQ_EN]) | (par_next & c3_next[`SCINB_C3_PARITY_IRQ_EN]);

    // single-wire direction; normal mode drives, loop-only releases
    if (cfg_next[`SCINB_CF_LOOP] && cfg_next[`SCINB_CF_RX_SOURCE_SELECT]) begin
      oe_next = c3_next[`SCINB_C3_DIR];
    end else begin
      oe_next = ~cfg_next[`SCINB_CF_LOOP];
    end
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      c3_reg <= `SCINB_RST_C3;
      cfg_reg <= `SCINB_RST_CFG;
      rxbuf_reg <= `SCINB_RST_DATA;
      rdf_reg <= 1'b0;
      ovr_reg <= 1'b0;
      nse_reg <= 1'b0;
      frm_reg <= 1'b0;
      par_reg <= 1'b0;
      rx_arm_reg <= SCINB_ARM_IDLE;
      tx_arm_reg <= SCINB_ARM_IDLE;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      oe_reg <= 1'b1;
    end else begin
      c3_reg <= c3_next;
      cfg_reg <= cfg_next;
      rxbuf_reg <= rxbuf_next;
      rdf_reg <= rdf_next;
      ovr_reg <= ovr_next;
      nse_reg <= nse_next;
      frm_reg <= frm_next;
      par_reg <= par_next;
      rx_arm_reg <= rx_arm_next;
      tx_arm_reg <= tx_arm_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      oe_reg <= oe_next;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_tx_valid = hold_full;
  assign o_tx_char = hold_data;
  assign o_nine_bit = cfg_reg[`SCINB_CF_NINE];
  assign o_tx_line_oe = oe_reg;
  assign o_err_irq = irq_reg;
endmodule

// [core/scinb_regs.svh]
/*
  register offsets, field positions and reset values for the serial ninth-bit,
  error-interrupt and data-register block.
  assumes inclusion by bare name from the top module, the checker and the bench.
*/
`ifndef SCINB_REGS_SVH
`define SCINB_REGS_SVH

// -------------------------------------------------------------
// register offsets (byte addresses, plain port)
// -------------------------------------------------------------
`define SCINB_OFF_STATUS_ONE 4'h0
`define SCINB_OFF_CONTROL_THREE 4'h1
`define SCINB_OFF_DATA 4'h2
`define SCINB_OFF_CONFIG 4'h3

// -------------------------------------------------------------
// serial_control_three fields
// -------------------------------------------------------------
`define SCINB_C3_RX9 7
`define SCINB_C3_TX9 6
`define SCINB_C3_DIR 5
`define SCINB_C3_OVERRUN_IRQ_EN 3
`define SCINB_C3_NOISE_IRQ_EN 2
`define SCINB_C3_FRAMING_IRQ_EN 1
`define SCINB_C3_PARITY_IRQ_EN 0

// -------------------------------------------------------------
// serial_status_one fields
// -------------------------------------------------------------
`define SCINB_S1_TDE 7
`define SCINB_S1_RDF 5
`define SCINB_S1_OVR 3
`define SCINB_S1_NSE 2
`define SCINB_S1_FRM 1
`define SCINB_S1_PAR 0

// -------------------------------------------------------------
// config register fields (nine-bit, loop, rx source)
// -------------------------------------------------------------
`define SCINB_CF_NINE 0
`define SCINB_CF_LOOP 1
`define SCINB_CF_RX_SOURCE_SELECT 2

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define SCINB_RST_DATA 8'h00
`define SCINB_RST_C3 8'h00
`define SCINB_RST_CFG 8'h00

`endif

// [core/scinb_pkg.sv]
/*
  types shared by the serial ninth-bit block.
  assumes the register header sits beside it.
*/
package scinb_pkg;
  // clearing-sequence arm states
  typedef enum logic [1:0] {
    SCINB_ARM_IDLE = 2'b01,
    SCINB_ARM_SET = 2'b10
  } scinb_arm_e;

  typedef logic [8:0] scinb_char_t;
endpackage

// [core/scinb_rx_if.sv]
/*
  interface carrying one received character with its error bits from the
  capture stage to the top module.
  assumes one clock; the strobe is a single-cycle pulse.
*/
`timescale 1ns/100ps
interface scinb_rx_if;
  import scinb_pkg::*;
  logic load;
  scinb_char_t data;
  logic noise;
  logic framing;
  logic parity;
  modport src (output load, output data, output noise, output framing, output parity);
  modport dst (input load, input data, input noise, input framing, input parity);
endinterface

// [core/scinb_rx_capture.sv]
/*
  second design file: brings the shifter's character-ready strobe and error
  bits into the bus clock domain and hands them on as one registered pulse.
  assumes the shifter strobe is asynchronous, held at least two clocks.
*/
`timescale 1ns/100ps
module scinb_rx_capture
  import scinb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ready,
  input wire logic [8:0] i_data,
  input wire logic [2:0] i_err,
  scinb_rx_if.src rx
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic load_reg;
  logic load_next;
  scinb_char_t data_reg;
  scinb_char_t data_next;
  logic [2:0] err_reg;
  logic [2:0] err_next;

  always_comb begin
    sync_next = {sync_reg[1:0], i_ready};
    // edge seen only on synchronised copies
    load_next = sync_reg[1] & ~sync_reg[2];
    data_next = load_next ? i_data : data_reg;
    err_next = load_next ? i_err : err_reg;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_reg <= 3'h0;
      load_reg <= 1'b0;
      data_reg <= 9'h000;
      err_reg <= 3'h0;
    end else begin
      sync_reg <= sync_next;
      load_reg <= load_next;
      data_reg <= data_next;
      err_reg <= err_next;
    end
  end

  assign rx.load = load_reg;
  assign rx.data = data_reg;
  assign rx.noise = err_reg[2];
  assign rx.framing = err_reg[1];
  assign rx.parity = err_reg[0];
endmodule

// [core/scinb_tx_hold.sv]
/*
  third design file: the transmit buffer, holding one 9-bit character until
  the shifter takes it or a new load replaces it.
  assumes the shifter's take strobe is on the same clock.
*/
`timescale 1ns/100ps
module scinb_tx_hold
  import scinb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire scinb_char_t i_data,
  input wire logic i_take,
  output logic o_full,
  output scinb_char_t o_data
);
  logic full_reg;
  logic full_next;
  scinb_char_t data_reg;
  scinb_char_t data_next;

  always_comb begin
    full_next = full_reg;
    data_next = data_reg;
    if (i_take) begin
      full_next = 1'b0;
    end
    // a new load wins over a take in the same cycle
    if (i_load) begin
      full_next = 1'b1;
      data_next = i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      full_reg <= 1'b0;
      data_reg <= 9'h000;
    end else begin
      full_reg <= full_next;
      data_reg <= data_next;
    end
  end

  assign o_full = full_reg;
  assign o_data = data_reg;
endmodule

// [verif/scinb_top_chk.sv]
/*
  checker bound to the serial ninth-bit block top.
  assumes the offsets and fields of scinb_regs.svh.
*/
`timescale 1ns/100ps
`include "scinb_regs.svh"
module scinb_top_chk (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_tx_take,
  input wire logic o_tx_valid,
  input wire logic [8:0] o_tx_char,
  input wire logic o_nine_bit,
  input wire logic o_tx_line_oe,
  input wire logic o_err_irq
);
  localparam logic [3:0] C3 = `SCINB_OFF_CONTROL_THREE;
  localparam logic [3:0] CF = `SCINB_OFF_CONFIG;
  logic [7:0] c3_reg;
  logic [2:0] cfg_reg;
  logic wd;
  logic quiet;
  logic oe_exp;
  assign wd = i_wr && i_addr == `SCINB_OFF_DATA;
  assign quiet = !(i_wr && (i_addr == C3 || i_addr == CF));
  assign oe_exp = (cfg_reg[2:1] == 2'b11) ? c3_reg[`SCINB_C3_DIR] : !cfg_reg[1];
  // shadow of the control bits, so outputs can be tied to what software wrote
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c3_reg <= 8'h00;
      cfg_reg <= 3'h0;
    end else if (i_wr && i_addr == C3) begin
      c3_reg <= i_wdata;
    end else if (i_wr && i_addr == CF) begin
      cfg_reg <= i_wdata[2:0];
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero");
  AST_TX_BYTE: assert property (wd |=> o_tx_valid && o_tx_char[7:0] == $past(i_wdata))
    else $error("tx byte not loaded");
  AST_TX_NINTH: assert property (wd |=> o_tx_char[8] == $past(c3_reg[`SCINB_C3_TX9]))
    else $error("tx ninth bit wrong");
  AST_TX_HOLD: assert property (o_tx_valid && !i_tx_take && !wd |=> o_tx_valid && $stable(o_tx_char))
    else $error("tx buffer changed");
  AST_TX_TAKE: assert property (i_tx_take && !wd |=> !o_tx_valid)
    else $error("tx buffer not emptied");
  AST_TDE_READ: assert property (i_rd && i_addr == `SCINB_OFF_STATUS_ONE |=>
    o_rdata[`SCINB_S1_TDE] == !$past(o_tx_valid))
    else $error("tx empty flag wrong");
  AST_RX9_OFF: assert property (i_rd && i_addr == C3 && !o_nine_bit |=> !o_rdata[`SCINB_C3_RX9])
    else $error("rx ninth bit shown in 8-bit mode");
  AST_OE_DIR: assert property (quiet [*2] |-> o_tx_line_oe == oe_exp)
    else $error("line direction wrong");
  AST_IRQ_MASKED: assert property (c3_reg[3:0] == 4'h0 && $past(c3_reg[3:0]) == 4'h0 |-> !o_err_irq)
    else $error("irq with all enables off");
  cover property (wd && c3_reg[`SCINB_C3_TX9]);
  cover property ($rose(o_err_irq));
  cover property (i_tx_take && o_tx_valid);
endmodule
bind scinb_top scinb_top_chk chk_u (.i_sys_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_tx_take, .o_tx_valid, .o_tx_char, .o_nine_bit, .o_tx_line_oe, .o_err_irq);

// [verif/scinb_node.sv]
/*
  remote serial node: hands received characters to the block and takes
  transmit characters from it.
  assumes one caller at a time, on the block's clock.
*/
`timescale 1ns/100ps
module scinb_node (
  input wire logic i_clk,
  input wire logic i_tx_valid,
  output logic o_rx_ready,
  output logic [8:0] o_rx_char,
  output logic [2:0] o_rx_err,
  output logic o_tx_take
);
  initial begin
    o_rx_ready = 1'b0;
    o_rx_char = 9'h000;
    o_rx_err = 3'h0;
    o_tx_take = 1'b0;
  end
  task automatic send(input logic [8:0] ch, input logic [2:0] err);
    @(posedge i_clk);
    o_rx_char <= ch;
    o_rx_err <= err;
    o_rx_ready <= 1'b1;
    repeat (5) @(posedge i_clk);
    // stale data would hide a late capture, so show the inverse
    o_rx_ready <= 1'b0;
    o_rx_char <= ~ch;
    o_rx_err <= ~err;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic take(input int slow);
    repeat (slow) @(posedge i_clk);
    o_tx_take <= i_tx_valid;
    @(posedge i_clk);
    o_tx_take <= 1'b0;
  endtask
endmodule

// [verif/scinb_top_tb.sv]
/*
  self-checking bench for the serial ninth-bit block, with a model of its
  registers and flags.
  assumes the node model and the bound checker.
*/
`timescale 1ns/100ps
`include "scinb_regs.svh"
module scinb_top_tb;
  localparam logic [3:0] ST = `SCINB_OFF_STATUS_ONE;
  localparam logic [3:0] C3 = `SCINB_OFF_CONTROL_THREE;
  localparam logic [3:0] DR = `SCINB_OFF_DATA;
  localparam logic [3:0] CF = `SCINB_OFF_CONFIG;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic rx_ready, tx_take, o_tx_valid, o_nine_bit, o_tx_line_oe, o_err_irq;
  logic [8:0] rx_char, o_tx_char;
  logic [2:0] rx_err;
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] m_c3 = 8'h00;
  logic [7:0] m_cfg = 8'h00;
  logic [7:0] m_st = 8'h80;
  logic m_arm = 1'b0;
  logic m_r9 = 1'b0;
  logic [8:0] m_tx = 9'h000;
  logic [8:0] m_rx[$];
  always #4 i_sys_clk = ~i_sys_clk;
  scinb_top dut_u (.i_sys_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_rx_ready(rx_ready),
    .i_rx_char(rx_char), .i_rx_err(rx_err), .i_tx_take(tx_take), .o_tx_valid, .o_tx_char, .o_nine_bit,
    .o_tx_line_oe, .o_err_irq);
  scinb_node node_u (.i_clk(i_sys_clk), .i_tx_valid(o_tx_valid), .o_rx_ready(rx_ready), .o_rx_char(rx_char),
    .o_rx_err(rx_err), .o_tx_take(tx_take));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    if (a == C3) m_c3 = d;
    if (a == CF) m_cfg = d;
    if (a == DR) begin
      m_tx = {m_c3[`SCINB_C3_TX9], d};
      m_st[7] = 1'b0;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk({1'b0, o_rdata}, {1'b0, e});
    if (a == ST) m_arm = |m_st[5:0];
    if (a == DR && m_arm) begin
      m_st[5:0] = 6'h00;
      m_rx.delete();
      m_arm = 1'b0;
    end
  endtask
  task automatic rx(input logic [8:0] ch, input logic [2:0] err);
    if (m_rx.size() != 0) begin
      m_st[`SCINB_S1_OVR] = 1'b1;
    end else begin
      m_rx.push_back(ch);
      m_r9 = ch[8];
      m_st[5] = 1'b1;
      m_st[2:0] = err;
    end
    node_u.send(ch, err);
  endtask
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    logic [8:0] ch;
    logic [7:0] en;
    void'($urandom(5));
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(ST, 8'h80);
    rd(C3, 8'h00);
    rd(DR, 8'h00);
    rd(4'hf, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(CF, {5'h00, i[2:0]});
      wr(C3, {2'b00, i[3], 5'h00});
      repeat (2) @(posedge i_sys_clk);
      chk(o_tx_line_oe, (i[2:1] == 2'b11) ? i[3] : !i[1]);
      chk(o_nine_bit, i[0]);
    end
    wr(CF, 8'h01);
    for (int i = 0; i < 4; i++) begin
      // ninth bit written only every other character
      if (!i[0]) wr(C3, {1'b0, i[1], 6'h00});
      rd(ST, m_st);
      en = $urandom;
      wr(DR, en);
      #1 chk(o_tx_char, m_tx);
      chk(o_tx_valid, 1'b1);
      rd(ST, m_st);
      rd(DR, 8'h00);
      if (i[0]) begin
        node_u.take(i);
        m_st[7] = 1'b1;
        @(posedge i_sys_clk);
        chk(o_tx_valid, 1'b0);
      end
    end
    for (int k = 0; k < 8; k++) begin
      en = k[0] ? 8'h01 << k[2:1] : 8'h0f ^ (8'h01 << k[2:1]);
      wr(CF, {7'h00, k[1]});
      wr(C3, en);
      ch = $urandom;
      rx(ch, (k[2:1] == 2'd3) ? 3'h0 : 3'h1 << k[2:1]);
      if (k[2:1] == 2'd3) rx(~ch, 3'h7);
      chk(o_err_irq, |(m_st[3:0] & m_c3[3:0]));
      wr(C3, 8'h00);
      @(posedge i_sys_clk);
      chk(o_err_irq, 1'b0);
      rd(ST, m_st);
      rd(C3, {m_cfg[0] & m_r9, 7'h00});
      rd(DR, m_rx[0][7:0]);
      rd(ST, m_st);
    end
    report_and_stop();
  end
endmodule
